/* design/cmu_compare_unit.v */
// Compare match unit: compare, pin action, special trigger, PWM and registers.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cmu_defs.vh"
module cmu_compare_unit #(
   parameter UNIT = 1,
   parameter PWM_W = `CMU_PWM_W
) (
   input wire mclk,
   input wire rst_n,
   input wire [`CMU_ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [7:0] regRdData_q,
   input wire [15:0] timerA,
   input wire [15:0] timerB,
   input wire useTimerB,
   input wire [PWM_W-1:0] pwmPeriod,
   input wire adcEnabled,
   output reg unitPin_q,
   output reg specialTrig_q,
   output reg timerAClear_q,
   output reg timerBClear_q,
   output reg suppressOvfFlag_q,
   output reg adcStart_q,
   output reg irq_q
);
   reg [7:0] cvLow_q;
   reg [7:0] cvHigh_q;
   reg [7:0] ctrl_q;
   reg cmpLatch_q;
   reg [`CMU_ST_W-1:0] status_q;
   reg [`CMU_ST_W-1:0] mask_q;
   reg matchSeen_q;
   wire pwmOut;
   wire [3:0] mode = ctrl_q[3:0];
   wire pwmMode = (mode[3:2] == 2'b11);
   wire [PWM_W-1:0] duty = {cvLow_q, ctrl_q[`CMU_DUTY_LSB+1:`CMU_DUTY_LSB]};
   wire [15:0] timerSel = useTimerB ? timerB : timerA;
   wire isCompare = (mode == `CMU_MODE_TOGGLE) || (mode == `CMU_MODE_SETHI) ||
      (mode == `CMU_MODE_SETLO) || (mode == `CMU_MODE_SWINT) || (mode == `CMU_MODE_TRIG);
   // Level match, acted on once per entry so a stalled timer does not retrigger.
   wire eqNow = isCompare && ({cvHigh_q, cvLow_q} == timerSel);
   wire match = eqNow && !matchSeen_q;
   wire trigUnit = (UNIT == 1) || (UNIT == 2);
   wire trigEv = match && (mode == `CMU_MODE_TRIG) && trigUnit;
   wire ctrlWr = regWrStb && (regAddr == `CMU_REG_CTRL);
   wire [7:0] ctrlNew = regWrData & `CMU_CTRL_MASK;
   wire [`CMU_ST_W-1:0] evts = {trigEv, match};
   wire [`CMU_ST_W-1:0] clrBits = (regWrStb && regAddr == `CMU_REG_STATUS) ?
      regWrData[`CMU_ST_W-1:0] : {`CMU_ST_W{1'b0}};
   reg [7:0] rd_d;

   cmu_pwm_gen #(.W(PWM_W)) pwmGen (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(pwmMode),
      .duty(duty),
      .period(pwmPeriod),
      .pwmOut_q(pwmOut)
   );

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cvLow_q <= 8'h00;
         cvHigh_q <= 8'h00;
         ctrl_q <= `CMU_CTRL_RESET;
         mask_q <= {`CMU_ST_W{1'b0}};
      end else if (regWrStb) begin
         case (regAddr)
            `CMU_REG_CVLOW: cvLow_q <= regWrData;
            `CMU_REG_CVHIGH: begin
               if (!pwmMode) begin
                  cvHigh_q <= regWrData;
               end
            end
            `CMU_REG_CTRL: ctrl_q <= ctrlNew;
            `CMU_REG_MASK: mask_q <= regWrData[`CMU_ST_W-1:0];
            default: ;
         endcase
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmpLatch_q <= 1'b0;
         matchSeen_q <= 1'b0;
         status_q <= {`CMU_ST_W{1'b0}};
      end else begin
         matchSeen_q <= eqNow;
         status_q <= (status_q & ~clrBits) | evts;
         if (ctrlWr) begin
            if (ctrlNew == 8'h00) begin
               cmpLatch_q <= 1'b0;
            end else if (ctrlNew[3:0] == `CMU_MODE_SETHI) begin
               cmpLatch_q <= 1'b0;
            end else if (ctrlNew[3:0] == `CMU_MODE_SETLO) begin
               cmpLatch_q <= 1'b1;
            end
         end else if (match) begin
            case (mode)
               `CMU_MODE_TOGGLE: cmpLatch_q <= ~cmpLatch_q;
               `CMU_MODE_SETHI: cmpLatch_q <= 1'b1;
               `CMU_MODE_SETLO: cmpLatch_q <= 1'b0;
               default: cmpLatch_q <= cmpLatch_q;
            endcase
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unitPin_q <= 1'b0;
         specialTrig_q <= 1'b0;
         timerAClear_q <= 1'b0;
         timerBClear_q <= 1'b0;
         suppressOvfFlag_q <= 1'b0;
         adcStart_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         // The compare latch already follows control writes of zero, so the pin follows one cycle later.
         unitPin_q <= pwmMode ? pwmOut : cmpLatch_q;
         specialTrig_q <= trigEv;
         timerAClear_q <= trigEv && !useTimerB;
         timerBClear_q <= trigEv && useTimerB;
         suppressOvfFlag_q <= trigEv && (UNIT == 2);
         adcStart_q <= trigEv && (UNIT == 2) && adcEnabled;
         irq_q <= |(((status_q & ~clrBits) | evts) & mask_q);
      end
   end

   always @* begin
      rd_d = 8'h00;
      case (regAddr)
         `CMU_REG_CVLOW: rd_d = cvLow_q;
         `CMU_REG_CVHIGH: rd_d = cvHigh_q;
         `CMU_REG_CTRL: rd_d = ctrl_q;
         `CMU_REG_STATUS: rd_d = {{(8-`CMU_ST_W){1'b0}}, status_q};
         `CMU_REG_MASK: rd_d = {{(8-`CMU_ST_W){1'b0}}, mask_q};
         `CMU_REG_PIN: rd_d = {7'h00, unitPin_q};
         default: rd_d = 8'h00;
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData_q <= 8'h00;
      end else if (regRdStb) begin
         regRdData_q <= rd_d;
      end else begin
         regRdData_q <= 8'h00;
      end
   end
endmodule // cmu_compare_unit
`default_nettype wire

/* design/cmu_defs.vh */
// Constants for the compare match unit.
`ifndef CMU_DEFS_VH
`define CMU_DEFS_VH
`define CMU_ADDR_W 3
`define CMU_REG_CVLOW 3'h0
`define CMU_REG_CVHIGH 3'h1
`define CMU_REG_CTRL 3'h2
`define CMU_REG_STATUS 3'h3
`define CMU_REG_MASK 3'h4
`define CMU_REG_PIN 3'h5
`define CMU_CTRL_RESET 8'h00
`define CMU_CTRL_MASK 8'h3f
`define CMU_MODE_OFF 4'h0
`define CMU_MODE_TOGGLE 4'h2
`define CMU_MODE_SETHI 4'h8
`define CMU_MODE_SETLO 4'h9
`define CMU_MODE_SWINT 4'ha
`define CMU_MODE_TRIG 4'hb
`define CMU_ST_MATCH 0
`define CMU_ST_TRIG 1
`define CMU_ST_W 2
`define CMU_DUTY_LSB 4
`define CMU_PWM_W 10
`endif

/* design/cmu_pwm_gen.v */
// Ten-bit PWM generator with period-boundary double buffering of the duty value.
`timescale 1ns/1ps
`default_nettype none
module cmu_pwm_gen #(
   parameter W = 10
) (
   input wire mclk,
   input wire rst_n,
   input wire enable,
   input wire [W-1:0] duty,
   input wire [W-1:0] period,
   output reg pwmOut_q
);
   reg [W-1:0] cnt_q;
   reg [W-1:0] dutyLatched_q;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {W{1'b0}};
         dutyLatched_q <= {W{1'b0}};
         pwmOut_q <= 1'b0;
      end else if (!enable) begin
         cnt_q <= {W{1'b0}};
         dutyLatched_q <= duty;
         pwmOut_q <= 1'b0;
      end else if (cnt_q == period) begin
         cnt_q <= {W{1'b0}};
         dutyLatched_q <= duty;
         pwmOut_q <= (duty != {W{1'b0}});
      end else begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         if (cnt_q + {{(W-1){1'b0}}, 1'b1} == dutyLatched_q) begin
            pwmOut_q <= 1'b0;
         end
      end
   end
endmodule // cmu_pwm_gen
`default_nettype wire

/* test/cmu_compare_unit_asserts.sv */
// Port assertions for the compare match unit.
`timescale 1ns/1ps
`default_nettype none
module cmu_compare_unit_asserts (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData_q,
   input wire logic useTimerB,
   input wire logic adcEnabled,
   input wire logic unitPin_q,
   input wire logic specialTrig_q,
   input wire logic timerAClear_q,
   input wire logic timerBClear_q,
   input wire logic suppressOvfFlag_q,
   input wire logic adcStart_q,
   input wire logic irq_q
);
   logic [3:0] mode_q;
   wire ctlWr = regWrStb && regAddr == 3'h2;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) mode_q <= 4'h0;
      else if (ctlWr) mode_q <= regWrData[3:0];
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_TRIG_SEL: assert property (specialTrig_q |->
      {timerAClear_q, timerBClear_q} == {!useTimerB, useTimerB}) else $error("bad clear");
   AST_ADC: assert property (adcStart_q |-> specialTrig_q && adcEnabled)
      else $error("bad start");
   AST_NO_OVF: assert property (timerAClear_q || timerBClear_q |-> suppressOvfFlag_q)
      else $error("no suppress");
   AST_TRIG_ONE: assert property (specialTrig_q |=> !specialTrig_q)
      else $error("long trigger");
   AST_TRIG_MODE: assert property (specialTrig_q |-> mode_q == 4'hb)
      else $error("stray trigger");
   AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData_q == 8'h00)
      else $error("stray read data");
   AST_ZERO_CTRL: assert property (ctlWr && regWrData == 8'h00 |-> ##2 !unitPin_q)
      else $error("pin not low");
   AST_PRESET_HI: assert property (ctlWr && regWrData[3:0] == 4'h9 |-> ##2 unitPin_q)
      else $error("pin not high");
   AST_SW_PIN: assert property (mode_q == 4'ha && $past(mode_q) == 4'ha |=> $stable(unitPin_q))
      else $error("pin moved");
   cover property (adcStart_q);
   cover property (timerAClear_q);
   cover property ($rose(irq_q));
endmodule // cmu_compare_unit_asserts
bind cmu_compare_unit cmu_compare_unit_asserts chk_u (.*);
`default_nettype wire

/* test/cmu_pin_load.sv */
// Load on the unit pin that counts the rising edges it sees.
`timescale 1ns/1ps
`default_nettype none
module cmu_pin_load (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pinLevel,
   output var logic [7:0] riseCount
);
   logic last;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) {riseCount, last} <= 9'h000;
      else {riseCount, last} <= {riseCount + {7'h00, pinLevel & ~last}, pinLevel};
   end
endmodule // cmu_pin_load
`default_nettype wire

/* test/cmu_compare_unit_test.sv */
// Self-checking bench for the compare match unit.
`timescale 1ns/1ps
`default_nettype none
module cmu_compare_unit_test;
   logic mclk, rst_n, regWrStb, regRdStb, useTimerB, adcEnabled, unitPin_q, irq_q;
   logic specialTrig_q, timerAClear_q, timerBClear_q, suppressOvfFlag_q, adcStart_q;
   logic [2:0] regAddr;
   logic [7:0] regWrData, regRdData_q, rises;
   logic [15:0] timerA, timerB;
   logic [9:0] pwmPeriod;
   int failures = 0, checks_done = 0, nA = 0, nB = 0, nAdc = 0, hiCnt, i;
   cmu_compare_unit #(.UNIT(2)) dut_u (.*);
   cmu_pin_load load_u (.mclk(mclk), .rst_n(rst_n), .pinLevel(unitPin_q), .riseCount(rises));
   always @(posedge mclk) begin
      nA <= nA + timerAClear_q;
      nB <= nB + timerBClear_q;
      nAdc <= nAdc + adcStart_q;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      {regWrStb, regAddr, regWrData} <= {1'b1, a, d};
      @(posedge mclk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      {regRdStb, regAddr} <= {1'b1, a};
      @(posedge mclk);
      regRdStb <= 1'b0;
      #1 chk({8'h00, regRdData_q}, {8'h00, e});
   endtask
   // Timers are stepped on mclk, as a synchronous timer would be.
   task automatic hit(input logic onB);
      @(posedge mclk);
      {timerA, timerB} <= onB ? {16'h0000, 16'h1234} : {16'h1234, 16'h0000};
      repeat (4) @(posedge mclk);
      {timerA, timerB} <= 32'h0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      failures++;
      tally_and_finish;
   end
   initial begin
      {rst_n, regWrStb, regRdStb, useTimerB, adcEnabled, regAddr, regWrData} = 16'h0;
      {timerA, timerB, pwmPeriod} = {32'h0, 10'h009};
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
      // Compare value goes in before the mode, so an idle timer at zero cannot match.
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      wr(3'h4, 8'h03);
      wr(3'h2, 8'hc2);
      rd(3'h2, 8'h02);
      hit(1'b1);
      rd(3'h3, 8'h00);
      hit(1'b0);
      rd(3'h5, 8'h01);
      chk(irq_q, 16'h1);
      hit(1'b0);
      rd(3'h3, 8'h01);
      chk(rises, 16'h1);
      wr(3'h3, 8'h01);
      rd(3'h3, 8'h00);
      wr(3'h2, 8'h08);
      hit(1'b0);
      rd(3'h5, 8'h01);
      wr(3'h2, 8'h00);
      rd(3'h5, 8'h00);
      wr(3'h2, 8'h09);
      wr(3'h2, 8'h0a);
      hit(1'b0);
      rd(3'h5, 8'h01);
      {useTimerB, adcEnabled} <= 2'b11;
      wr(3'h2, 8'h0b);
      hit(1'b1);
      {useTimerB, adcEnabled} <= 2'b00;
      hit(1'b0);
      chk(nB + nA * 16 + nAdc * 256, 16'h0111);
      rd(3'h3, 8'h03);
      wr(3'h2, 8'h00);
      wr(3'h0, 8'h01);
      wr(3'h2, 8'h0c);
      repeat (30) @(posedge mclk);
      hiCnt = 0;
      repeat (100) @(negedge mclk) hiCnt += unitPin_q;
      chk(hiCnt, 16'd40);
      wr(3'h2, 8'h00);
      rd(3'h5, 8'h00);
      tally_and_finish;
   end
endmodule // cmu_compare_unit_test
`default_nettype wire
